//--- ecm_pkg.sv
// Package of register offsets, field layouts and carrier types for the monitor bank
package ecm_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [6:0] ECM_OFS_SEND_INPUT_LEVEL     = 7'h1e;
  localparam logic [6:0] ECM_OFS_SEND_OUTPUT_LEVEL    = 7'h1f;
  localparam logic [6:0] ECM_OFS_RECEIVE_INPUT_LEVEL  = 7'h20;
  localparam logic [6:0] ECM_OFS_SEND_INPUT_OFFSET    = 7'h21;
  localparam logic [6:0] ECM_OFS_SEND_OUTPUT_OFFSET   = 7'h22;
  localparam logic [6:0] ECM_OFS_ARTIFICIAL_ECHO      = 7'h23;
  localparam logic [6:0] ECM_OFS_BACKGROUND_NOISE     = 7'h24;
  localparam logic [6:0] ECM_OFS_ECHO_RETURN_LOSS     = 7'h25;
  localparam logic [6:0] ECM_OFS_COMBINED_LOSS        = 7'h26;
  localparam logic [6:0] ECM_OFS_SUPPRESSOR_THRESHOLD = 7'h27;
  localparam logic [6:0] ECM_OFS_OVERCOMP_DOUBLETALK  = 7'h28;
  localparam logic [6:0] ECM_OFS_SEND_INPUT_SAMPLE    = 7'h29;
  localparam logic [6:0] ECM_OFS_SEND_OUTPUT_SAMPLE   = 7'h2a;
  localparam logic [6:0] ECM_OFS_RECEIVE_INPUT_SAMPLE = 7'h2b;
  localparam logic [6:0] ECM_OFS_CONTROL_STATE_ONE    = 7'h2c;
  localparam logic [6:0] ECM_OFS_TIMESLOT_WATCH_CTRL  = 7'h2f;
  localparam logic [6:0] ECM_OFS_FILTER_TAP_VALUE_DATA_HIGH       = 7'h7b;
  localparam logic [6:0] ECM_OFS_FILTER_TAP_VALUE_DATA_LOW        = 7'h7c;
  localparam logic [6:0] ECM_OFS_AUX_FILTER_TAP_VALUE_DATA        = 7'h7d;

  // Field positions
  localparam int ECM_FINAL_TAP_BIT   = 7;
  localparam int ECM_TAP_SIGN_BIT    = 13;
  localparam int ECM_LIN_SIGN_BIT    = 17;
  localparam int ECM_TAP_EXP_LSB     = 10;
  localparam int ECM_WATCH_VALID_BIT = 7;

  // Reset values
  localparam logic [7:0] ECM_RST_BYTE  = 8'h00;
  localparam logic [4:0] ECM_RST_CHAN  = 5'h00;
  localparam logic [13:0] ECM_RST_TAP  = 14'h0000;

  // Level code landmarks
  localparam logic [7:0] ECM_LEVEL_MAX     = 8'hbf;
  localparam logic [7:0] ECM_LEVEL_ZERO_DB = 8'hb8;
  localparam logic [7:0] ECM_LEVEL_SILENCE = 8'h00;

  // Per-channel monitor values, one set per channel
  typedef struct packed {
    logic [7:0] send_input_level;
    logic [7:0] send_output_level;
    logic [7:0] receive_input_level;
    logic [5:0] send_input_offset;
    logic [5:0] send_output_offset;
    logic [7:0] artificial_echo_level;
    logic [6:0] background_noise_level;
    logic [7:0] echo_return_loss;
    logic [7:0] combined_loss;
    logic [7:0] suppressor_threshold_level;
    logic [3:0] overcompensation_eval;
    logic [3:0] doubletalk_hangover_time;
    logic [7:0] send_input_sample;
    logic [7:0] send_output_sample;
    logic [7:0] receive_input_sample;
    logic [7:0] control_state_flags_one;
  } ecm_chan_mon_t;

  // One coefficient handed over by the filter readout engine
  typedef struct packed {
    logic        final_tap_flag;
    logic [13:0] filter_tap_value;
    logic [9:0]  secondary_tap_value;
  } ecm_tap_t;

  // Register port
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ecm_bus_req_t;

endpackage : ecm_pkg

//--- ecm_monitor_regs.sv
// Monitor register bank: coefficient readout and per-channel monitor values
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Low tap register top bit marks final tap
// - Low tap register holds tap bits five-zero
// - Tap code: sign, exponent, mantissa to linear
// - Auxiliary register holds secondary tap bits nine-two
// - Monitors show only the selected channel
// - Sample monitors hold 8-bit companded PCM
// - Level code 191 is +3, 16 per 6dB
// - Code 184 0dBm0, 1 -69, 0 silence
// - Seven level monitors are 8-bit log codes
// - Noise level is 7-bit, top bit zero
// - Offsets are 6-bit ones-complement, upper zero
// - Overcomp high nibble, hang-over low nibble
// - Control flags one bit order fixed
// - High tap register holds tap bits thirteen-six
// - Reading high tap register acknowledges availability
module ecm_monitor_regs
  import ecm_pkg::*;
#(
  parameter int NUM_CHAN = 32
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    clk_en_in,
  // Register port
  input  wire logic [6:0]              reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [7:0]              reg_rdata_out,
  // Monitor values of every channel from the cancelling datapath
  input  wire ecm_chan_mon_t [NUM_CHAN-1:0] chan_mon_in,
  // Pulse from the datapath: monitor values have been refreshed
  input  wire logic                    watch_update_in,
  // Coefficient handed over by the readout engine
  input  wire ecm_tap_t                tap_in,
  input  wire logic                    tap_valid_in,
  output logic                         tap_ready_out,
  // Status towards the device interrupt logic
  output logic                         tap_available_irq_out,
  output logic                         watch_update_valid_out,
  // Linear form of the held coefficient, for the host-facing debug view
  output logic      [17:0]             tap_linear_out
);

  // Channel select must fit the 5-bit field
  if (NUM_CHAN < 1 || NUM_CHAN > 32) begin : g_chk
    $error("NUM_CHAN must lie between 1 and 32");
  end

  // Held state
  logic [4:0]    watched_channel_select_r;
  logic          watch_update_valid_r;
  ecm_tap_t      tap_r;
  logic          tap_held_r;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;

  // Bus decode
  wire ecm_bus_req_t bus_req = '{addr: reg_addr_in, wdata: reg_wdata_in,
                                 wr: reg_wr_in, rd: reg_rd_in};
  wire logic wr_ctrl   = bus_req.wr && (bus_req.addr == ECM_OFS_TIMESLOT_WATCH_CTRL);
  wire logic rd_ctrl   = bus_req.rd && (bus_req.addr == ECM_OFS_TIMESLOT_WATCH_CTRL);
  wire logic rd_high   = bus_req.rd && (bus_req.addr == ECM_OFS_FILTER_TAP_VALUE_DATA_HIGH);

  // selected channel only; out of range reads as the last channel
  wire logic [4:0] sel_ch = (32'(watched_channel_select_r) < NUM_CHAN) ?
                            watched_channel_select_r : 5'(NUM_CHAN - 1);
  wire ecm_chan_mon_t mon = chan_mon_in[sel_ch];

  // take the next tap only once the previous is acknowledged
  assign tap_ready_out = clk_en_in && (!tap_held_r || rd_high);

  // sign, exponent and mantissa of the held tap
  wire logic       tap_sign = tap_r.filter_tap_value[ECM_TAP_SIGN_BIT];
  wire logic [2:0] tap_exp  = tap_r.filter_tap_value[ECM_TAP_EXP_LSB +: 3];
  wire logic [9:0] tap_man  = tap_r.filter_tap_value[9:0];
  wire logic [16:0] tap_norm = {6'h00, 1'b1, tap_man};
  // magnitude: mantissa, or hidden one plus mantissa shifted by exponent minus one
  wire logic [16:0] tap_mag = (tap_exp == 3'h0) ? {7'h00, tap_man} :
                              17'(tap_norm << (tap_exp - 3'h1));
  wire logic [17:0] tap_linear = {tap_sign, tap_mag};

  // Read data mux; level codes pass straight through, the datapath owns the log scale
  always_comb begin
    rdata_nxt = ECM_RST_BYTE;
    case (bus_req.addr)
      ECM_OFS_SEND_INPUT_LEVEL:     rdata_nxt = mon.send_input_level;
      ECM_OFS_SEND_OUTPUT_LEVEL:    rdata_nxt = mon.send_output_level;
      ECM_OFS_RECEIVE_INPUT_LEVEL:  rdata_nxt = mon.receive_input_level;
      ECM_OFS_SEND_INPUT_OFFSET:    rdata_nxt = {2'b00, mon.send_input_offset};
      ECM_OFS_SEND_OUTPUT_OFFSET:   rdata_nxt = {2'b00, mon.send_output_offset};
      // shared log code, values carried unchanged
      ECM_OFS_ARTIFICIAL_ECHO:      rdata_nxt = mon.artificial_echo_level;
      ECM_OFS_BACKGROUND_NOISE:     rdata_nxt = {1'b0, mon.background_noise_level};
      ECM_OFS_ECHO_RETURN_LOSS:     rdata_nxt = mon.echo_return_loss;
      ECM_OFS_COMBINED_LOSS:        rdata_nxt = mon.combined_loss;
      ECM_OFS_SUPPRESSOR_THRESHOLD: rdata_nxt = mon.suppressor_threshold_level;
      ECM_OFS_OVERCOMP_DOUBLETALK:  rdata_nxt = {mon.overcompensation_eval,
                                                 mon.doubletalk_hangover_time};
      ECM_OFS_SEND_INPUT_SAMPLE:    rdata_nxt = mon.send_input_sample;
      ECM_OFS_SEND_OUTPUT_SAMPLE:   rdata_nxt = mon.send_output_sample;
      ECM_OFS_RECEIVE_INPUT_SAMPLE: rdata_nxt = mon.receive_input_sample;
      // flag order as delivered by the datapath
      ECM_OFS_CONTROL_STATE_ONE:    rdata_nxt = mon.control_state_flags_one;
      ECM_OFS_TIMESLOT_WATCH_CTRL:  rdata_nxt = {watch_update_valid_r, 2'b00,
                                                 watched_channel_select_r};
      ECM_OFS_FILTER_TAP_VALUE_DATA_HIGH:       rdata_nxt = tap_r.filter_tap_value[13:6];
      // final flag, unused bit, low tap bits
      ECM_OFS_FILTER_TAP_VALUE_DATA_LOW:        rdata_nxt = {tap_r.final_tap_flag, 1'b0,
                                                 tap_r.filter_tap_value[5:0]};
      ECM_OFS_AUX_FILTER_TAP_VALUE_DATA:        rdata_nxt = tap_r.secondary_tap_value[9:2];
      default:                      rdata_nxt = ECM_RST_BYTE;
    endcase
  end

  // Read data register: valid in the cycle after an enabled read strobe, held while the clock enable is low
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= ECM_RST_BYTE;
    end else if (clk_en_in) begin
      rdata_r <= bus_req.rd ? rdata_nxt : ECM_RST_BYTE;
    end
  end

  // Watch control: channel select and valid flag; set wins over host clear
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      watched_channel_select_r <= ECM_RST_CHAN;
      watch_update_valid_r     <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_ctrl) begin
        watched_channel_select_r <= bus_req.wdata[4:0];
      end
      // host writes zero to the flag once it has read the monitors
      if (watch_update_in) begin
        watch_update_valid_r <= 1'b1;
      end else if (wr_ctrl && !bus_req.wdata[ECM_WATCH_VALID_BIT]) begin
        watch_update_valid_r <= 1'b0;
      end
    end
  end

  // Tap holding register; monitor registers themselves take no writes
  // only the control word accepts host data
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tap_r      <= '{final_tap_flag: 1'b0, filter_tap_value: ECM_RST_TAP,
                      secondary_tap_value: 10'h000};
      tap_held_r <= 1'b0;
    end else if (clk_en_in) begin
      // acknowledge on high read, a new tap in the same cycle wins
      if (tap_valid_in && tap_ready_out) begin
        tap_r      <= tap_in;
        tap_held_r <= 1'b1;
      end else if (rd_high) begin
        tap_held_r <= 1'b0;
      end
    end
  end

  // Outputs
  assign reg_rdata_out          = rdata_r;
  assign tap_available_irq_out  = tap_held_r;
  assign watch_update_valid_out = watch_update_valid_r;
  assign tap_linear_out         = tap_linear;

  // Control read is not side-effecting; kept for completeness of decode
  wire logic unused_rd_ctrl = rd_ctrl;

endmodule // ecm_monitor_regs
`default_nettype wire

//--- ecm_monitor_regs_props.sv
// Timing checker for the monitor register bank ports
`timescale 1ns/10ps
`default_nettype none
module ecm_monitor_regs_props
  import ecm_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic        clk_en_in,
  input wire logic [6:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        watch_update_in,
  input wire logic        tap_valid_in,
  input wire logic        tap_ready_out,
  input wire logic        tap_available_irq_out,
  input wire logic        watch_update_valid_out,
  input wire logic [17:0] tap_linear_out
);
  // Qualified requests; a low clock enable takes nothing
  wire rd_w   = reg_rd_in && clk_en_in;
  wire take_w = tap_valid_in && tap_ready_out && clk_en_in;
  wire ack_w  = rd_w && (reg_addr_in == ECM_OFS_FILTER_TAP_VALUE_DATA_HIGH);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // A frozen clock enable holds the last read byte, so only a running idle cycle clears it
  property p_rd_idle; clk_en_in && !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_low_gap; rd_w && reg_addr_in == 7'h7c |=> !reg_rdata_out[6]; endproperty
  a_low_gap: assert property (p_low_gap) else $error("unused tap bit set");
  property p_noise; rd_w && reg_addr_in == 7'h24 |=> !reg_rdata_out[7]; endproperty
  a_noise: assert property (p_noise) else $error("noise top bit set");
  property p_ofs; rd_w && reg_addr_in inside {7'h21, 7'h22} |=> reg_rdata_out[7:6] == 2'h0;
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset upper bits set");
  property p_sign; ack_w |=> reg_rdata_out[7] == $past(tap_linear_out[17]); endproperty
  a_sign: assert property (p_sign) else $error("sign mismatch");
  property p_take; take_w |=> tap_available_irq_out; endproperty
  a_take: assert property (p_take) else $error("tap not flagged");
  property p_refuse; tap_available_irq_out && !ack_w |-> !tap_ready_out; endproperty
  a_refuse: assert property (p_refuse) else $error("ready while held");
  property p_ack; ack_w && !take_w |=> !tap_available_irq_out; endproperty
  a_ack: assert property (p_ack) else $error("tap not released");
  property p_valid; watch_update_in && clk_en_in |=> watch_update_valid_out; endproperty
  a_valid: assert property (p_valid) else $error("valid flag not set");
endmodule // ecm_monitor_regs_props
bind ecm_monitor_regs ecm_monitor_regs_props u_props (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .watch_update_in(watch_update_in),
  .tap_valid_in(tap_valid_in), .tap_ready_out(tap_ready_out),
  .tap_available_irq_out(tap_available_irq_out),
  .watch_update_valid_out(watch_update_valid_out), .tap_linear_out(tap_linear_out));
`default_nettype wire

//--- tb.sv
// Self-checking bench of the monitor register bank
`timescale 1ns/10ps
`default_nettype none
module tb
  import ecm_pkg::*;
;
  logic                 mclk_in, rstn_in, clk_en_in, reg_wr_in, reg_rd_in;
  logic                 watch_update_in, tap_valid_in, tap_ready_out;
  logic                 tap_available_irq_out, watch_update_valid_out;
  logic [6:0]           reg_addr_in;
  logic [7:0]           reg_wdata_in, reg_rdata_out;
  logic [17:0]          tap_linear_out;
  ecm_chan_mon_t [3:0]  chan_mon_in;
  ecm_tap_t             tap_in, tap_v;
  int                   err_total = 0;
  int                   n_tests = 0;
  // Rows of address and expected byte for channel 2
  logic [14:0]          rows [15] = '{{7'h1e, 8'hbf}, {7'h1f, 8'hb8}, {7'h20, 8'h01},
    {7'h21, 8'h2a}, {7'h22, 8'h15}, {7'h23, 8'h00}, {7'h24, 8'h55}, {7'h25, 8'h88},
    {7'h26, 8'h10}, {7'h27, 8'h08}, {7'h28, 8'ha5}, {7'h29, 8'hd5}, {7'h2a, 8'h2a},
    {7'h2b, 8'h7f}, {7'h2c, 8'h81}};

  ecm_monitor_regs #(.NUM_CHAN(4)) u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .chan_mon_in(chan_mon_in), .watch_update_in(watch_update_in), .tap_in(tap_in),
    .tap_valid_in(tap_valid_in), .tap_ready_out(tap_ready_out),
    .tap_available_irq_out(tap_available_irq_out),
    .watch_update_valid_out(watch_update_valid_out), .tap_linear_out(tap_linear_out));

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bus cycles start just after an edge and release after the taking edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
    @(posedge mclk_in);
  endtask
  // Linear magnitude: mantissa, or hidden one plus mantissa shifted by exponent-1
  function automatic logic [17:0] lin(input logic [13:0] c);
    logic [17:0] m;
    m = (c[12:10] == 3'h0) ? {8'h00, c[9:0]} : ({7'h00, 1'b1, c[9:0]} << (c[12:10] - 3'h1));
    return {c[13], m[16:0]};
  endfunction

  // Clock at 40 MHz
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Watchdog well beyond the roughly 120 cycles the run needs
  initial begin
    repeat (2000) @(posedge mclk_in);
    err_total++;
    test_done;
  end
  // Main sequence
  initial begin
    {rstn_in, reg_wr_in, reg_rd_in, watch_update_in, tap_valid_in} = 5'h00;
    clk_en_in = 1'b1;
    reg_addr_in = 7'h00;
    reg_wdata_in = 8'h00;
    tap_in = '0;
    chan_mon_in = '0;
    chan_mon_in[2] = '{8'hbf, 8'hb8, 8'h01, 6'h2a, 6'h15, 8'h00, 7'h55, 8'h88, 8'h10, 8'h08,
      4'ha, 4'h5, 8'hd5, 8'h2a, 8'h7f, 8'h81};
    chan_mon_in[3] = '1;
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    chk({tap_available_irq_out, watch_update_valid_out}, 18'h0);
    rdc(ECM_OFS_TIMESLOT_WATCH_CTRL, 8'h00);
    wr(ECM_OFS_TIMESLOT_WATCH_CTRL, 8'h02);
    foreach (rows[i]) rdc(rows[i][14:8], rows[i][7:0]);
    wr(7'h1e, 8'h00);
    rdc(7'h1e, 8'hbf);
    wr(ECM_OFS_TIMESLOT_WATCH_CTRL, 8'h07);
    rdc(7'h24, 8'h7f);
    rdc(7'h50, 8'h00);
    watch_update_in <= 1'b1;
    @(posedge mclk_in);
    watch_update_in <= 1'b0;
    rdc(ECM_OFS_TIMESLOT_WATCH_CTRL, 8'h87);
    wr(ECM_OFS_TIMESLOT_WATCH_CTRL, 8'h07);
    rdc(ECM_OFS_TIMESLOT_WATCH_CTRL, 8'h07);
    // Every exponent, last tap flagged final
    for (int e = 0; e < 8; e++) begin
      tap_v = '{e == 7, {e[0], e[2:0], 10'h2a5}, 10'h3c7};
      chk(tap_ready_out, 1'b1);
      tap_in       <= tap_v;
      tap_valid_in <= 1'b1;
      @(posedge mclk_in);
      tap_valid_in <= 1'b0;
      #1 chk({tap_available_irq_out, tap_ready_out}, 18'h2);
      chk(tap_linear_out, lin(tap_v.filter_tap_value));
      @(posedge mclk_in);
      rdc(ECM_OFS_FILTER_TAP_VALUE_DATA_LOW, {e == 7, 1'b0, 6'h25});
      rdc(ECM_OFS_AUX_FILTER_TAP_VALUE_DATA, 8'hf1);
      rdc(ECM_OFS_FILTER_TAP_VALUE_DATA_HIGH, tap_v.filter_tap_value[13:6]);
      chk(tap_available_irq_out, 1'b0);
    end
    // Mid-run reset drops a held tap and the valid flag
    tap_in       <= tap_v;
    tap_valid_in <= 1'b1;
    watch_update_in <= 1'b1;
    @(posedge mclk_in);
    tap_valid_in <= 1'b0;
    watch_update_in <= 1'b0;
    rstn_in      <= 1'b0;
    #1 chk({tap_available_irq_out, watch_update_valid_out}, 18'h0);
    @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    #1 chk(tap_ready_out, 1'b1);
    @(posedge mclk_in);
    // Frozen clock enable withholds ready and ignores a refresh pulse
    clk_en_in <= 1'b0;
    watch_update_in <= 1'b1;
    @(posedge mclk_in);
    watch_update_in <= 1'b0;
    #1 chk(tap_ready_out, 1'b0);
    chk(watch_update_valid_out, 1'b0);
    test_done;
  end
endmodule // tb
`default_nettype wire
